/* logic/scb_capture.sv */
// Two-channel sample capture buffer with APB control.
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.svh"
module scb_capture
  import scb_pkg::*;
#(
  parameter int unsigned DEPTH       = `SCB_DEPTH,
  parameter int unsigned AW          = `SCB_AW,
  parameter int unsigned DW          = `SCB_DW,
  parameter int unsigned TICK_CYCLES = `SCB_TICK_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [DW-1:0] channel_one_display,
  input  wire logic [DW-1:0] channel_two_display,
  input  wire logic          trigger_in,
  output logic               full_alarm,
  output logic               storing
);
  ////////////////////////////////////////////////////////////////////////////////////////////
  scb_state_t           state;
  logic [3:0]           sample_rate_select;
  logic                 loop_mode;
  logic                 trigger_starts_scan_select;
  logic [AW-1:0]        wr_ptr;
  logic [AW-1:0]        count;
  logic                 wrapped;
  logic [AW-1:0]        oldest_point_index;
  logic [AW-1:0]        rd_bin;
  logic [2*DW-1:0]      rd_data;
  logic [2*DW-1:0]      mem [DEPTH];
  logic                 trig_q;
  logic                 sw_trig;
  logic                 trig_edge;
  logic [31:0]          holdoff;
  logic                 trig_ok;
  logic                 rate_tick;
  logic                 sample_ev;
  logic                 wr_en;
  logic                 rd_en;
  logic                 begin_storage_command;
  logic                 hold_storage_command;
  logic                 clear_buffer_command;
  logic                 start_ev;
  logic                 trig_mode;
  logic                 running;
  logic                 full;
  logic                 mapped;
  logic [31:0]          next_prdata;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] v);
    wrap_inc = (v == AW'(DEPTH - 1)) ? '0 : AW'(v + 1'b1);
  endfunction : wrap_inc

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB decode: zero-wait access, unmapped offsets answer with an error.
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign mapped  = (paddr == `SCB_OFF_CTRL) || (paddr == `SCB_OFF_CMD) ||
                   (paddr == `SCB_OFF_STATUS) || (paddr == `SCB_OFF_COUNT) ||
                   (paddr == `SCB_OFF_RD_BIN) || (paddr == `SCB_OFF_RD_DATA) ||
                   (paddr == `SCB_OFF_SWTRIG);
  assign pslverr = psel && penable && !mapped;

  wire cmd_wr = wr_en && (paddr == `SCB_OFF_CMD);
  assign begin_storage_command = cmd_wr && pwdata[`SCB_CMD_START];
  assign hold_storage_command  = cmd_wr && pwdata[`SCB_CMD_HOLD];
  assign clear_buffer_command  = cmd_wr && pwdata[`SCB_CMD_CLEAR];
  assign sw_trig               = wr_en && (paddr == `SCB_OFF_SWTRIG) && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_rate_select         <= 4'h0;
      loop_mode                  <= 1'b1;
      trigger_starts_scan_select <= 1'b0;
    end else if (wr_en && paddr == `SCB_OFF_CTRL) begin
      // Codes above trigger are not legal; they are kept out so the rate stays defined.
      if (pwdata[`SCB_CTRL_RATE_MSB:`SCB_CTRL_RATE_LSB] <= `SCB_TRIG_CODE) begin
        sample_rate_select <= pwdata[`SCB_CTRL_RATE_MSB:`SCB_CTRL_RATE_LSB];
      end
      loop_mode                  <= pwdata[`SCB_CTRL_LOOP];
      trigger_starts_scan_select <= pwdata[`SCB_CTRL_TSTART];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_bin <= '0;
    end else if (wr_en && paddr == `SCB_OFF_RD_BIN) begin
      rd_bin <= pwdata[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Trigger edge with 512 Hz hold-off; the software trigger acts as the pin does.
  assign trig_edge = (trigger_in && !trig_q) || sw_trig;
  assign trig_ok   = trig_edge && (holdoff == 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trigger_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdoff <= 32'h0;
    end else if (trig_ok) begin
      holdoff <= TICK_CYCLES - 1;
    end else if (holdoff != 32'h0) begin
      holdoff <= holdoff - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  assign trig_mode = (sample_rate_select == `SCB_TRIG_CODE);
  assign running   = (state == SCB_RUN);
  assign storing   = running;
  assign full      = (count == AW'(DEPTH));

  scb_rate_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_rate (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (running && !trig_mode),
    .code      (sample_rate_select),
    .tick      (rate_tick),
    .base_tick ()
  );

  // Sampling is immediate on the accepted edge, far inside the 2 ms bound.
  assign sample_ev = running && (trig_mode ? trig_ok : rate_tick);
  // The trigger that starts a triggered scan is not also a sample.
  assign start_ev  = begin_storage_command ||
                     (trigger_starts_scan_select && trig_ok && state != SCB_RUN);

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SCB_IDLE;
    end else if (clear_buffer_command) begin
      state <= SCB_IDLE;
    end else begin
      unique case (state)
        SCB_IDLE, SCB_PAUSED: begin
          if (start_ev) begin
            state <= SCB_RUN;
          end
        end
        SCB_RUN: begin
          if (hold_storage_command) begin
            state <= SCB_PAUSED;
          end else if (sample_ev && !loop_mode && count == AW'(DEPTH - 1)) begin
            state <= SCB_PAUSED;
          end
        end
        SCB_ARMED: begin
          state <= SCB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (sample_ev) begin
      mem[wr_ptr] <= {channel_two_display, channel_one_display};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr  <= '0;
      count   <= '0;
      wrapped <= 1'b0;
    end else if (clear_buffer_command) begin
      wr_ptr  <= '0;
      count   <= '0;
      wrapped <= 1'b0;
    end else if (sample_ev) begin
      wr_ptr <= wrap_inc(wr_ptr);
      if (!full) begin
        count <= AW'(count + 1'b1);
      end
      if (wr_ptr == AW'(DEPTH - 1)) begin
        wrapped <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_alarm <= 1'b0;
    end else if (sample_ev && !loop_mode && count == AW'(DEPTH - 1) && !clear_buffer_command) begin
      // The fill event wins over a start in the same cycle; only a clear in the same cycle keeps the alarm from being set.
      full_alarm <= 1'b1;
    end else if (clear_buffer_command || begin_storage_command) begin
      full_alarm <= 1'b0;
    end
  end

  // After a wrap the oldest point sits at the write position.
  assign oldest_point_index = wrapped ? wr_ptr : '0;

  always_ff @(posedge pclk) begin
    rd_data <= mem[AW'(({1'b0, oldest_point_index} + {1'b0, rd_bin}) % (AW + 1)'(DEPTH))];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      `SCB_OFF_CTRL: begin
        next_prdata = {26'h0, trigger_starts_scan_select, loop_mode, sample_rate_select};
      end
      `SCB_OFF_STATUS: begin
        next_prdata = {28'h0, full_alarm, wrapped, state == SCB_PAUSED, running};
      end
      `SCB_OFF_COUNT:   next_prdata = 32'(count);
      `SCB_OFF_RD_BIN:  next_prdata = 32'(rd_bin);
      `SCB_OFF_RD_DATA: next_prdata = 32'(rd_data);
      default:          next_prdata = 32'h0;
    endcase
  end

  assign prdata = rd_en ? next_prdata : 32'h0;
endmodule : scb_capture
`default_nettype wire

/* logic/scb_regs.svh */
// Register offsets, field positions, reset values and timing counts of the capture buffer.
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH
`define SCB_DEPTH          16383
`define SCB_AW             14
`define SCB_DW             16
`define SCB_CLK_HZ         50000000
`define SCB_MAX_RATE_HZ    512
`define SCB_TICK_CYCLES    (`SCB_CLK_HZ / `SCB_MAX_RATE_HZ)
`define SCB_TRIG_CODE      4'he
`define SCB_RATE_CODES     14
`define SCB_OFF_CTRL       12'h000
`define SCB_OFF_CMD        12'h004
`define SCB_OFF_STATUS     12'h008
`define SCB_OFF_COUNT      12'h00c
`define SCB_OFF_RD_BIN     12'h010
`define SCB_OFF_RD_DATA    12'h014
`define SCB_OFF_SWTRIG     12'h018
`define SCB_CTRL_RATE_LSB  0
`define SCB_CTRL_RATE_MSB  3
`define SCB_CTRL_LOOP      4
`define SCB_CTRL_TSTART    5
`define SCB_CMD_START      0
`define SCB_CMD_HOLD       1
`define SCB_CMD_CLEAR      2
`define SCB_CTRL_RESET     6'h10
`endif

/* logic/scb_pkg.sv */
// Types shared by the capture buffer files.
package scb_pkg;
  typedef enum logic [1:0] {
    SCB_IDLE,
    SCB_ARMED,
    SCB_RUN,
    SCB_PAUSED
  } scb_state_t;
endpackage : scb_pkg

/* logic/scb_rate_gen.sv */
// Sample rate divider producing a one-cycle tick at the selected rate.
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.svh"
module scb_rate_gen
  import scb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SCB_TICK_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [3:0] code,
  output logic            tick,
  output logic            base_tick
);
  logic [31:0] base_cnt;
  logic [12:0] oct_cnt;
  logic [12:0] mask;

  assign base_tick = (base_cnt == TICK_CYCLES - 1);
  // Code 13 is the base 512 Hz rate; each lower code halves it.
  assign mask = (code >= 4'hd) ? 13'h0000 : 13'(13'h1fff >> code);
  assign tick = run && base_tick && ((oct_cnt & mask) == 13'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt <= 32'h0;
    end else if (!run || base_tick) begin
      base_cnt <= 32'h0;
    end else begin
      base_cnt <= base_cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oct_cnt <= 13'h0;
    end else if (!run) begin
      oct_cnt <= 13'h0;
    end else if (base_tick) begin
      oct_cnt <= oct_cnt + 13'h1;
    end
  end
endmodule : scb_rate_gen
`default_nettype wire

/* test/scb_capture_monitor.sv */
// Port-level checker of the capture buffer.
`timescale 1ns/1ps
`default_nettype none
module scb_capture_monitor #(
  parameter int unsigned DW = 16
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [DW-1:0] channel_one_display,
  input wire logic [DW-1:0] channel_two_display,
  input wire logic          trigger_in,
  input wire logic          full_alarm,
  input wire logic          storing
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr  = acc && pwrite;
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> acc) else $error("error outside access");
  a_err_unmapped: assert property (acc && paddr >= 12'h01c |-> pslverr)
    else $error("unmapped access accepted");
  a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  // A trigger passes the edge detector in the cycle it rises, so one cycle back is enough; two are allowed.
  a_start_cause: assert property ($rose(storing) |-> $past(wr) || $past(trigger_in)
    || $past(trigger_in, 2)) else $error("storage began uncommanded");
  a_stop_cause: assert property ($fell(storing) |-> $past(wr) || full_alarm)
    else $error("storage stopped uncommanded");
  a_alarm_stops: assert property ($rose(full_alarm) |-> !storing)
    else $error("alarm while storing");
  a_alarm_clear: assert property ($fell(full_alarm) |-> $past(wr))
    else $error("alarm dropped uncommanded");
endmodule : scb_capture_monitor
bind scb_capture scb_capture_monitor #(.DW(DW)) mon_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_one_display,
  .channel_two_display, .trigger_in, .full_alarm, .storing);
`default_nettype wire

/* test/scb_source_model.sv */
// Far-side model: display sources and trigger input.
`timescale 1ns/1ps
`default_nettype none
module scb_source_model (
  input  wire logic        fire,
  input  wire logic [15:0] v1,
  input  wire logic [15:0] v2,
  output logic             trigger_in,
  output logic [15:0]      channel_one_display,
  output logic [15:0]      channel_two_display
);
  // Displays follow the requested values directly; a real source has no hold-off.
  assign trigger_in          = fire;
  assign channel_one_display = v1;
  assign channel_two_display = v2;
endmodule : scb_source_model
`default_nettype wire

/* test/sample_capture_buffer_ctrl_tb.sv */
// Self-checking bench of the sample capture buffer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module sample_capture_buffer_ctrl_tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} scb_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, n;
  logic        pready, pslverr, full_alarm, storing, trigger_in, err;
  logic [15:0] v1 = '0, v2 = '0, channel_one_display, channel_two_display;
  int          fails = 0, checks_done = 0, cyc = 0;
  scb_row_t    rows [9] = '{'{0, 12'h000, 0, 32'h10, 0}, '{0, 12'h00c, 0, 0, 0},
    '{0, 12'h008, 0, 0, 0}, '{1, 12'h01c, 32'hff, 0, 1}, '{1, 12'h000, 32'h1d, 0, 0},
    '{0, 12'h000, 0, 32'h1d, 0}, '{1, 12'h000, 32'h0f, 0, 0}, '{0, 12'h000, 0, 32'h0d, 0},
    '{1, 12'h000, 32'h1d, 0, 0}};
  scb_capture #(.TICK_CYCLES(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .channel_one_display, .channel_two_display,
    .trigger_in, .full_alarm, .storing);
  scb_source_model src_u (.fire, .v1, .v2, .trigger_in, .channel_one_display,
    .channel_two_display);
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #10 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  task automatic bin(input logic [31:0] b, input logic [31:0] e);
    apb(1, 12'h010, b);
    rdc(12'h014, e);
  endtask : bin
  // One-cycle pulse; the gap sets the spacing to the next rising edge.
  task automatic trig(input int gap);
    @(posedge pclk); fire <= 1;
    @(posedge pclk); fire <= 0;
    repeat (gap) @(posedge pclk);
  endtask : trig
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // The single-pass fill needs 16383 * 4 cycles, so the ceiling sits above that.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(rd, rows[i].e)
      `CHK(err, rows[i].er)
    end
    v1 <= 16'h1111; v2 <= 16'h2222;
    apb(1, 12'h004, 32'h1);
    @(negedge pclk) `CHK(storing, 1'b1)
    repeat (40) @(posedge pclk);
    apb(1, 12'h004, 32'h2);
    apb(0, 12'h00c, 0);
    n = rd;
    `CHK(n >= 9 && n <= 11, 1'b1)
    repeat (40) @(posedge pclk);
    rdc(12'h00c, n);
    apb(1, 12'h004, 32'h2);
    rdc(12'h008, 32'h2);
    bin(0, 32'h22221111);
    v1 <= 16'h3333; v2 <= 16'h4444;
    apb(1, 12'h004, 32'h1);
    repeat (40) @(posedge pclk);
    apb(1, 12'h004, 32'h2);
    apb(0, 12'h00c, 0);
    bin(rd - 1, 32'h44443333);
    bin(n - 1, 32'h22221111);
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h004, 32'h4);
    @(negedge pclk) `CHK(storing, 1'b0)
    rdc(12'h00c, 0);
    apb(1, 12'h000, 32'h1e);
    apb(1, 12'h004, 32'h1);
    repeat (3) trig(10);
    rdc(12'h00c, 3);
    trig(1);
    trig(10);
    rdc(12'h00c, 4);
    apb(1, 12'h018, 32'h1);
    rdc(12'h00c, 5);
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h000, 32'h3e);
    trig(10);
    @(negedge pclk) `CHK(storing, 1'b1)
    rdc(12'h00c, 0);
    trig(10);
    rdc(12'h00c, 1);
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h000, 32'h3d);
    trig(40);
    apb(0, 12'h00c, 0);
    `CHK(rd >= 9 && rd <= 11, 1'b1)
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h000, 32'h0d);
    apb(1, 12'h004, 32'h1);
    while (full_alarm !== 1'b1) @(posedge pclk);
    @(negedge pclk) `CHK(storing, 1'b0)
    rdc(12'h00c, 32'd16383);
    rdc(12'h008, 32'he);
    v1 <= 16'h5555; v2 <= 16'h6666;
    apb(1, 12'h004, 32'h1);
    @(negedge pclk) `CHK(full_alarm, 1'b0)
    repeat (40) @(posedge pclk);
    apb(1, 12'h004, 32'h2);
    rdc(12'h00c, 32'd16383);
    bin(16382, 32'h66665555);
    bin(0, 32'h44443333);
    // A reset in mid-run must drop storage and bring back the power-up settings.
    apb(1, 12'h004, 32'h1);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk) `CHK(storing, 1'b0)
    rdc(12'h00c, 0);
    rdc(12'h000, 32'h10);
    stop_test();
  end
endmodule : sample_capture_buffer_ctrl_tb
`default_nettype wire
